// File: spi_port_params.svh
// Purpose: Shared offsets, field positions, reset values and timing counts
// Assumes: 100 MHz system clock on both ends
// Notes:   Included by both ends of the serial link
`ifndef SPI_PORT_PARAMS_SVH
`define SPI_PORT_PARAMS_SVH

// --------------------------------------------------------------------
// Frame layout
// --------------------------------------------------------------------
`define FRAME_BITS       16
`define RW_BIT           15
`define ADDR_MSB         14
`define ADDR_LSB         9
`define PARITY_BIT       8
`define CNT_OVER         5'd17

// --------------------------------------------------------------------
// Device register map
// --------------------------------------------------------------------
`define ADDR_IC_STAT     6'h00
`define ADDR_STAT1       6'h01
`define ADDR_STATUS_REGISTER_TWO       6'h02
`define ADDR_CTRL_FIRST  6'h03
`define ADDR_LAST        6'h0c
`define ADDR_CLR_REG     6'h04
`define FAULT_CLEAR_BIT_POS      0
`define STAT_RST         8'h00
`define CTRL_RST         8'h00
`define CTRL2_RST        8'h60
`define CTRL3_RST        8'h46
`define CTRL4_RST        8'h10
`define IC_FAULT_POS     0
`define IC_OT_POS        1
`define IC_OVP_POS       2
`define IC_NO_POWER_ON_RESET_FLAG_POS      3
`define IC_OCP_POS       4
`define IC_SPI_POS       5
`define IC_BUCK_POS      6
`define ST2_PARITY_POS   2
`define ST2_FRAME_POS    1
`define ST2_ADDR_POS     0

// --------------------------------------------------------------------
// Controller APB map
// --------------------------------------------------------------------
`define APB_CMD          12'h000
`define APB_STAT         12'h004
`define APB_PINS         12'h008
`define STAT_BUSY_POS    16
`define STAT_FAULT_POS   17
`define PINS_RST         8'h01

// --------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------
`define CLK_PERIOD_NS    10
`define RST_WINDOW_NS    20000
`define RST_WINDOW_CYC   (`RST_WINDOW_NS / `CLK_PERIOD_NS)
`define CS_GAP_NS        400
`define CS_GAP_CYC       ((`CS_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCLK_HALF_CYC    8

`endif

// File: spi_port_pkg.sv
// Purpose: Types shared by both ends of the serial link
// Assumes: Nothing beyond the params header
// Notes:   Timing and offsets live in spi_port_params.svh
`default_nettype none
package spi_port_pkg;
	typedef logic [7:0]  byte_t;
	typedef logic [15:0] frame_t;
	typedef enum logic [2:0] {
		st_idle  = 3'b000,
		st_lead  = 3'b001,
		st_high  = 3'b010,
		st_low   = 3'b011,
		st_trail = 3'b100,
		st_gap   = 3'b101
	} ctl_state_t;
endpackage
`default_nettype wire

// File: spi_link_if.sv
// Purpose: Pin bundle between the serial controller and the driver port
// Assumes: Open-drain fault line and tristate data line resolved here
// Notes:   Undriven lines read high as with a pull-up
`default_nettype none
interface spi_link_if;
	logic       sclk;
	logic       chip_select_n;
	logic       sdi;
	logic       sdo_out;
	logic       sdo_oe;
	logic       sdo;
	logic       sleep_n_pin;
	logic       driver_disable_pin;
	logic       fault_n_out;
	logic       fault_n_oe;
	logic       fault_n_pin;
	logic [2:0] high_side_phase_input;
	logic [2:0] low_side_phase_input;

	assign sdo         = sdo_oe ? sdo_out : 1'b1;
	assign fault_n_pin = fault_n_oe ? fault_n_out : 1'b1;

	modport dev (
		input  sclk, chip_select_n, sdi, sleep_n_pin, driver_disable_pin,
		input  high_side_phase_input, low_side_phase_input,
		output sdo_out, sdo_oe, fault_n_out, fault_n_oe
	);
	modport ctl (
		output sclk, chip_select_n, sdi, sleep_n_pin, driver_disable_pin,
		output high_side_phase_input, low_side_phase_input,
		input  sdo, fault_n_pin
	);
endinterface
`default_nettype wire

// File: spi_config_status_port.sv
// Purpose: Driver-side serial port with status registers and fault handling
// Assumes: Detector inputs are synchronous to clk_i; link pins are not
// Notes:   Link pins pass two flops; edges found on the sampled clock
//
// Overview of operation
// RL1: Latched fault forces partial driver shutdown; code turns all six gates off
// RL2: Clear bit or reset pulse resumes operation
// RL3: Long sleep low begins full sleep
// RL4: Reset pulse clears faults only
// RL5: Disable pin turns all switches off
// RL6: Disable pin suppresses driver fault detection
// RL7: Frame is rw, address, parity, data
// RL8: Controller sets even frame parity
// RL9: Reply is status byte then data
// RL10: Write returns old data, read current
// RL11: Controller holds clock low at select edges
// RL12: Select high at least 400 ns
// RL13: Deselected port ignores inputs, output off
// RL14: Sample falling, shift rising, MSB first
// RL15: Wrong bit count discards the frame
// RL16: Short frame sets latched framing flag
// RL17: Address above 0xC sets latched flag
// RL18: Sleep and power-up reset all registers
// RL19: Summary status register flag layout
// RL20: Status one thermal and overcurrent layout
// RL21: Status registers at 0-2, read-only, zero reset; address 0 bit 3 follows power_on_done_i, so it reads 0x08
// RL22: Disable pin may pull fault line low
// RL23: Status two parity, framing, address bits
// RL24: Serial errors set summary fault bits
//
// Chosen here: the APB slave port.
`default_nettype none
`include "spi_port_params.svh"
module spi_config_status_port
	import spi_port_pkg::*;
#(
	parameter int RST_WINDOW_CYC = `RST_WINDOW_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	spi_link_if.dev         link,
	input  wire logic       thermal_warning_i,
	input  wire logic       thermal_shutdown_i,
	input  wire logic       supply_overvoltage_i,
	input  wire logic       power_on_done_i,
	input  wire logic       buck_fault_i,
	input  wire logic [5:0] overcurrent_i,
	input  wire logic [3:0] supply_aux_fault_i,
	output logic      [2:0] high_gate_o,
	output logic      [2:0] low_gate_o,
	output logic            asleep_o
);
	localparam int CTRL_LO = 3;
	localparam int CTRL_HI = 12;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Order: sclk, cs_n, sdi, sleep_n, drv_dis, high[3], low[3]
	localparam logic [10:0] SYNC_RST = 11'h00a;
	logic [10:0] meta_r;
	logic [10:0] sync_r;
	logic        sclk_prev_r;
	logic        cs_prev_r;
	logic        sleep_prev_r;
	wire  [10:0] pins_w = {link.low_side_phase_input, link.high_side_phase_input,
	                       link.driver_disable_pin, link.sleep_n_pin, link.sdi,
	                       link.chip_select_n, link.sclk};

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_r       <= SYNC_RST;
			sync_r       <= SYNC_RST;
			sclk_prev_r  <= 1'b0;
			cs_prev_r    <= 1'b1;
			sleep_prev_r <= 1'b1;
		end else begin
			meta_r       <= pins_w;
			sync_r       <= meta_r;
			sclk_prev_r  <= sync_r[0];
			cs_prev_r    <= sync_r[1];
			sleep_prev_r <= sync_r[3];
		end
	end

	wire       sclk_s  = sync_r[0];
	wire       cs_n_s  = sync_r[1];
	wire       sdi_s   = sync_r[2];
	wire       sleep_s = sync_r[3];
	wire       drv_dis = sync_r[4];
	wire [2:0] hs_in   = sync_r[7:5];
	wire [2:0] ls_in   = sync_r[10:8];

	// ------------------------------------------------------------
	// Sleep pin: reset pulse versus sleep entry
	// ------------------------------------------------------------
	logic [15:0] low_cnt_r;
	logic        asleep_r;
	wire         sleep_rise = sleep_s & ~sleep_prev_r;
	// RL3: long low enters sleep
	wire         sleep_due  = ~sleep_s & (low_cnt_r == 16'(RST_WINDOW_CYC - 1));
	// RL2: short low pulse clears faults
	wire         pulse_clr  = sleep_rise & ~asleep_r;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			low_cnt_r <= 16'h0000;
			asleep_r  <= 1'b0;
		end else begin
			low_cnt_r <= (sleep_s || sleep_due) ? 16'h0000 : low_cnt_r + 16'h0001;
			asleep_r  <= sleep_s ? 1'b0 : (asleep_r | sleep_due);
		end
	end

	// ------------------------------------------------------------
	// Frame receive and transmit
	// ------------------------------------------------------------
	logic [4:0] bit_cnt_r;
	frame_t     rx_r;
	frame_t     tx_r;
	logic       sdo_r;
	logic       sdo_oe_r;
	byte_t      ic_stat;
	byte_t      stat1_r;
	byte_t      status_register_two_r;
	byte_t      ctrl_r [CTRL_HI:CTRL_LO];

	// RL13: nothing is seen while deselected
	wire active   = ~cs_n_s & ~asleep_r;
	// RL14: sample on falling, shift on rising
	wire sclk_fal = active & sclk_prev_r & ~sclk_s;
	wire sclk_ris = active & ~sclk_prev_r & sclk_s;
	wire cs_fall  = cs_prev_r & ~cs_n_s & ~asleep_r;
	wire cs_rise  = ~cs_prev_r & cs_n_s & ~asleep_r;

	// Address is complete with the seventh sampled bit
	wire [5:0] early_addr = {rx_r[4:0], sdi_s};
	wire       early_ctrl = (early_addr >= `ADDR_CTRL_FIRST) && (early_addr <= `ADDR_LAST);
	wire [3:0] early_idx  = early_addr[3:0];
	// RL10: register value before this frame's write
	wire byte_t rd_data   = (early_addr == `ADDR_IC_STAT) ? ic_stat :
	                        (early_addr == `ADDR_STAT1)   ? stat1_r :
	                        (early_addr == `ADDR_STATUS_REGISTER_TWO)   ? status_register_two_r :
	                        early_ctrl                    ? ctrl_r[early_idx] : `STAT_RST;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bit_cnt_r <= 5'd0;
			rx_r      <= 16'h0000;
			tx_r      <= 16'h0000;
		end else if (cs_fall) begin
			bit_cnt_r <= 5'd0;
			// RL9: status byte leads the reply; the first rise brings out its MSB
			tx_r      <= {1'b0, ic_stat, 7'h00};
		end else if (cs_rise) begin
			// Output rests low so the next select shows no stray data edge
			tx_r      <= 16'h0000;
		end else if (sclk_fal) begin
			// RL14: most significant bit first
			rx_r      <= {rx_r[14:0], sdi_s};
			bit_cnt_r <= (bit_cnt_r == `CNT_OVER) ? bit_cnt_r : bit_cnt_r + 5'd1;
			if (bit_cnt_r == 5'd6) begin
				tx_r[13:6] <= rd_data;
			end
		end else if (sclk_ris) begin
			tx_r <= {tx_r[14:0], 1'b0};
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sdo_r    <= 1'b0;
			sdo_oe_r <= 1'b0;
		end else begin
			sdo_r    <= tx_r[15];
			// RL13: output released while deselected
			sdo_oe_r <= active;
		end
	end
	assign link.sdo_out = sdo_r;
	assign link.sdo_oe  = sdo_oe_r;

	// ------------------------------------------------------------
	// End of frame checks and register writes
	// ------------------------------------------------------------
	// RL7: field positions of the input frame
	wire [5:0] f_addr    = rx_r[`ADDR_MSB:`ADDR_LSB];
	wire       f_write   = ~rx_r[`RW_BIT];
	wire [3:0] f_idx     = f_addr[3:0];
	// RL15: exactly sixteen clocks
	wire       f_len_ok  = (bit_cnt_r == 5'(`FRAME_BITS));
	// RL8: even count of ones over the frame
	wire       f_par_ok  = ~^rx_r;
	wire       f_good    = cs_rise & f_len_ok & f_par_ok;
	// RL16: short frame flagged
	wire       frame_err = cs_rise & (bit_cnt_r < 5'(`FRAME_BITS));
	wire       par_err   = cs_rise & f_len_ok & ~f_par_ok;
	// RL17: address outside 0x0..0xC flagged
	wire       addr_err  = f_good & (f_addr > `ADDR_LAST);
	wire       wr_ctrl   = f_good & f_write & (f_addr >= `ADDR_CTRL_FIRST) & (f_addr <= `ADDR_LAST);
	// RL2: clear bit write clears latched faults
	wire       wr_clr    = wr_ctrl & (f_addr == `ADDR_CLR_REG) & rx_r[`FAULT_CLEAR_BIT_POS];
	wire       clr       = wr_clr | pulse_clr;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = CTRL_LO; i <= CTRL_HI; i++) begin
				ctrl_r[i] <= `CTRL_RST;
			end
			ctrl_r[4] <= `CTRL2_RST;
			ctrl_r[5] <= `CTRL3_RST;
			ctrl_r[6] <= `CTRL4_RST;
		end else if (asleep_r) begin
			// RL18: sleep restores defaults
			for (int i = CTRL_LO; i <= CTRL_HI; i++) begin
				ctrl_r[i] <= `CTRL_RST;
			end
			ctrl_r[4] <= `CTRL2_RST;
			ctrl_r[5] <= `CTRL3_RST;
			ctrl_r[6] <= `CTRL4_RST;
		end else if (wr_ctrl) begin
			// RL15: only good frames store; clear bit never stored
			ctrl_r[f_idx] <= (f_addr == `ADDR_CLR_REG) ? (rx_r[7:0] & ~8'h01) : rx_r[7:0];
		end
	end

	// ------------------------------------------------------------
	// Latched status and fault handling
	// ------------------------------------------------------------
	logic ovp_r;
	logic buck_r;
	logic shutdown_r;
	logic fault_oe_r;
	// RL6: driver faults ignored while disabled
	wire [5:0] oc_set   = overcurrent_i & {6{~drv_dis}};
	// RL20: warning, shutdown, then C/B/A high-low
	wire byte_t s1_set  = {thermal_warning_i, thermal_shutdown_i, oc_set};
	// RL23: parity, framing and address positions; top bit zero
	wire byte_t s2_set  = {1'b0, supply_aux_fault_i, par_err, frame_err, addr_err};
	wire       spi_any  = |status_register_two_r[`ST2_PARITY_POS:`ST2_ADDR_POS];
	wire       any_flt  = spi_any | (|stat1_r) | (|status_register_two_r) | ovp_r | buck_r;

	// RL19: summary flag layout
	// RL24: serial errors raise summary bits
	always_comb begin
		ic_stat                = `STAT_RST;
		ic_stat[`IC_FAULT_POS] = any_flt;
		ic_stat[`IC_OT_POS]    = |stat1_r[7:6];
		ic_stat[`IC_OVP_POS]   = ovp_r;
		ic_stat[`IC_NO_POWER_ON_RESET_FLAG_POS]  = power_on_done_i;
		ic_stat[`IC_OCP_POS]   = |stat1_r[5:0];
		ic_stat[`IC_SPI_POS]   = spi_any;
		ic_stat[`IC_BUCK_POS]  = buck_r;
	end

	// RL21: read-only, zero after reset
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stat1_r    <= `STAT_RST;
			status_register_two_r    <= `STAT_RST;
			ovp_r      <= 1'b0;
			buck_r     <= 1'b0;
			shutdown_r <= 1'b0;
		end else if (asleep_r) begin
			stat1_r    <= `STAT_RST;
			status_register_two_r    <= `STAT_RST;
			ovp_r      <= 1'b0;
			buck_r     <= 1'b0;
			shutdown_r <= 1'b0;
		end else begin
			// RL4: a clear touches the fault flags only; set beats clear
			stat1_r    <= (stat1_r & {8{~clr}}) | s1_set;
			status_register_two_r    <= (status_register_two_r & {8{~clr}}) | s2_set;
			ovp_r      <= (ovp_r & ~clr) | supply_overvoltage_i;
			buck_r     <= (buck_r & ~clr) | buck_fault_i;
			// RL1: stay shut down until cleared with cause gone
			shutdown_r <= (shutdown_r & ~clr) | (|oc_set) | thermal_shutdown_i;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fault_oe_r  <= 1'b0;
			high_gate_o <= 3'b000;
			low_gate_o  <= 3'b000;
		end else begin
			// RL22: disable pin also pulls the fault line
			fault_oe_r  <= any_flt | drv_dis;
			// RL5: disable overrides the phase inputs
			high_gate_o <= hs_in & {3{~drv_dis & ~shutdown_r & ~asleep_r}};
			low_gate_o  <= ls_in & {3{~drv_dis & ~shutdown_r & ~asleep_r}};
		end
	end

	assign link.fault_n_out = 1'b0;
	assign link.fault_n_oe  = fault_oe_r;
	assign asleep_o         = asleep_r;
endmodule
`default_nettype wire

// File: spi_port_controller.sv
// Purpose: Serial link controller driven by software over APB
// Assumes: APB on clk_i; one frame in flight at a time
// Notes:   Commands arriving while busy are dropped
`default_nettype none
`include "spi_port_params.svh"
module spi_port_controller
	import spi_port_pkg::*;
#(
	parameter int HALF_CYC = `SCLK_HALF_CYC,
	parameter int GAP_CYC  = `CS_GAP_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	spi_link_if.ctl          link
);
	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	ctl_state_t state_r;
	frame_t     tx_r;
	frame_t     rx_r;
	byte_t      pins_r;
	logic [1:0] sdo_meta_r;
	logic [1:0] flt_meta_r;
	wire        busy     = (state_r != st_idle);
	wire        hit_cmd  = (paddr == `APB_CMD);
	wire        hit_stat = (paddr == `APB_STAT);
	wire        hit_pins = (paddr == `APB_PINS);
	wire        mapped   = hit_cmd | hit_stat | hit_pins;
	wire        wr_acc   = psel & penable & pwrite;
	wire        start    = wr_acc & hit_cmd & ~busy;
	// RL8: parity makes the ones count even
	wire        par_bit  = ^{pwdata[15:9], pwdata[7:0]};
	wire frame_t cmd_w   = {pwdata[15:9], par_bit, pwdata[7:0]};
	wire [31:0] rd_mux   = hit_stat ? {14'h0000, ~flt_meta_r[1], busy, rx_r} :
	                       hit_pins ? {24'h000000, pins_r} : 32'h00000000;

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prdata <= 32'h00000000;
			pins_r <= `PINS_RST;
		end else begin
			if (psel && !penable) begin
				prdata <= rd_mux;
			end
			if (wr_acc && hit_pins) begin
				pins_r <= pwdata[7:0];
			end
		end
	end

	assign link.sleep_n_pin           = pins_r[0];
	assign link.driver_disable_pin    = pins_r[1];
	assign link.high_side_phase_input = pins_r[4:2];
	assign link.low_side_phase_input  = pins_r[7:5];

	// ------------------------------------------------------------
	// Frame sequencer
	// ------------------------------------------------------------
	logic [5:0] tmr_r;
	logic [3:0] bit_r;
	logic       sclk_r;
	logic       cs_n_r;
	wire        half_end = (tmr_r == 6'(HALF_CYC - 1));
	wire        gap_end  = (tmr_r == 6'(GAP_CYC - 1));

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sdo_meta_r <= 2'b11;
			flt_meta_r <= 2'b11;
		end else begin
			sdo_meta_r <= {sdo_meta_r[0], link.sdo};
			flt_meta_r <= {flt_meta_r[0], link.fault_n_pin};
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_r <= st_idle;
			tmr_r   <= 6'd0;
			bit_r   <= 4'd0;
			sclk_r  <= 1'b0;
			cs_n_r  <= 1'b1;
			tx_r    <= 16'h0000;
			rx_r    <= 16'h0000;
		end else begin
			tmr_r <= tmr_r + 6'd1;
			unique case (state_r)
				st_idle: begin
					tmr_r <= 6'd0;
					if (start) begin
						// RL11: clock low at select fall
						cs_n_r  <= 1'b0;
						tx_r    <= cmd_w;
						bit_r   <= 4'd0;
						state_r <= st_lead;
					end
				end
				st_lead: begin
					if (half_end) begin
						tmr_r   <= 6'd0;
						sclk_r  <= 1'b1;
						state_r <= st_high;
					end
				end
				st_high: begin
					if (half_end) begin
						// RL14: reply bit taken before the falling edge
						tmr_r   <= 6'd0;
						rx_r    <= {rx_r[14:0], sdo_meta_r[1]};
						sclk_r  <= 1'b0;
						bit_r   <= bit_r + 4'd1;
						state_r <= (bit_r == 4'd15) ? st_trail : st_low;
					end
				end
				st_low: begin
					if (half_end) begin
						// RL14: next bit out with the rising edge
						tmr_r   <= 6'd0;
						sclk_r  <= 1'b1;
						tx_r    <= {tx_r[14:0], 1'b0};
						state_r <= st_high;
					end
				end
				st_trail: begin
					if (half_end) begin
						tmr_r   <= 6'd0;
						cs_n_r  <= 1'b1;
						state_r <= st_gap;
					end
				end
				st_gap: begin
					// RL12: select stays high 400 ns
					if (gap_end) begin
						state_r <= st_idle;
					end
				end
				default: begin
					state_r <= st_idle;
				end
			endcase
		end
	end

	assign link.sclk          = sclk_r;
	assign link.chip_select_n = cs_n_r;
	assign link.sdi           = tx_r[15];
endmodule
`default_nettype wire

// File: spi_link_checker.sv
// Purpose: Protocol checks on the link between controller and port
// Assumes: One system clock domain for both ends
// Notes:   Instantiated beside the joining interface
`default_nettype none
module spi_link_checker (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic sclk,
	input wire logic chip_select_n,
	input wire logic sdi,
	input wire logic sdo_out,
	input wire logic sdo_oe,
	input wire logic fault_n_oe,
	input wire logic driver_disable_pin
);
	logic [5:0] gap_r;
	logic [4:0] rise_r;

	// ----------------------------------------
	// Select gap and clock counters
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			gap_r <= 6'h3f;
		else if (!chip_select_n)
			gap_r <= 6'h00;
		else if (gap_r != 6'h3f)
			gap_r <= gap_r + 6'h01;
	end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			rise_r <= 5'h00;
		else if (chip_select_n)
			rise_r <= 5'h00;
		else if ($rose(sclk))
			rise_r <= rise_r + 5'h01;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	AST_SCLK_AT_SELECT: assert property ($changed(chip_select_n) |-> !sclk)
		else $error("clock high at select edge");
	AST_SCLK_IDLE: assert property (chip_select_n |-> !sclk)
		else $error("clock moves while deselected");
	AST_SELECT_GAP: assert property ($fell(chip_select_n) |-> gap_r >= 6'h28)
		else $error("select gap too short");
	AST_SIXTEEN_CLOCKS: assert property ($rose(chip_select_n) |-> rise_r == 5'h10)
		else $error("frame not sixteen clocks");
	AST_HALF_PERIOD: assert property ($rose(sclk) |-> sclk [*8])
		else $error("clock high phase too short");
	AST_SDI_HOLD: assert property ($fell(sclk) |-> $stable(sdi))
		else $error("data in moved at sample edge");
	AST_SDO_RELEASE: assert property (chip_select_n [*8] |-> !sdo_oe)
		else $error("data out driven while deselected");
	AST_SDO_DRIVE: assert property ($fell(chip_select_n) |-> ##[1:6] sdo_oe)
		else $error("data out not driven in frame");
	AST_SDO_ON_RISE: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo_out) |-> sclk)
		else $error("data out changed in low phase");
	AST_DISABLE_FAULT: assert property (driver_disable_pin [*6] |-> fault_n_oe)
		else $error("fault line not pulled on disable");

	cover property ($rose(chip_select_n));
	cover property ($rose(fault_n_oe));
	cover property (driver_disable_pin && fault_n_oe);
endmodule
`default_nettype wire

// File: spi_config_status_port_bench.sv
// Purpose: Self-checking bench for controller and port joined
// Assumes: Reset pulse window shortened to 50 cycles
// Notes:   A second port is driven by hand for short frames
`default_nettype none
`include "spi_port_params.svh"
module spi_config_status_port_bench import spi_port_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_i = 1'b0, arst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        pready, pslverr, asleep_o, e, warn_i = 1'b0;
	logic        tsd_i = 1'b0, ovp_i = 1'b0, no_power_on_reset_flag_i = 1'b1, buck_i = 1'b0;
	logic [3:0]  aux_i = 4'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [5:0]  oc_i = 6'h00;
	logic [2:0]  hg_o, lg_o;
	frame_t      r;
	int          num_errors = 0, n_tests = 0;
	spi_link_if  link();
	spi_link_if  link2();

	spi_config_status_port #(.RST_WINDOW_CYC(50)) spi_config_status_port_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.link(link.dev), .thermal_warning_i(warn_i), .thermal_shutdown_i(tsd_i), .supply_overvoltage_i(ovp_i),
		.power_on_done_i(no_power_on_reset_flag_i), .buck_fault_i(buck_i), .overcurrent_i(oc_i), .supply_aux_fault_i(aux_i),
		.high_gate_o(hg_o), .low_gate_o(lg_o), .asleep_o(asleep_o));
	spi_config_status_port #(.RST_WINDOW_CYC(50)) second_spi_config_status_port_i (.clk_i(clk_i),
		.arst_n_i(arst_n_i), .link(link2.dev), .thermal_warning_i(warn_i), .thermal_shutdown_i(tsd_i),
		.supply_overvoltage_i(ovp_i), .power_on_done_i(no_power_on_reset_flag_i), .buck_fault_i(buck_i), .overcurrent_i(oc_i),
		.supply_aux_fault_i(aux_i), .high_gate_o(), .low_gate_o(), .asleep_o());
	spi_port_controller spi_port_controller_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(link.ctl));
	spi_link_checker spi_link_checker_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .sclk(link.sclk),
		.chip_select_n(link.chip_select_n), .sdi(link.sdi), .sdo_out(link.sdo_out), .sdo_oe(link.sdo_oe),
		.fault_n_oe(link.fault_n_oe), .driver_disable_pin(link.driver_disable_pin));

	always #5 clk_i = ~clk_i;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input frame_t got, input frame_t exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do @(posedge clk_i); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic xfer(input frame_t cmd, input frame_t exp, input frame_t m = 16'hffff);
		apb(1'b1, `APB_CMD, {16'h0, cmd});
		repeat (4) @(posedge clk_i);
		do apb(1'b0, `APB_STAT, 32'h0); while (q[`STAT_BUSY_POS] !== 1'b0);
		chk(q[15:0] & m, exp);
	endtask
	task automatic gates(input logic [5:0] exp);
		repeat (8) @(posedge clk_i);
		@(negedge clk_i);
		chk({10'h0, lg_o, hg_o}, {10'h0, exp});
	endtask
	task automatic bang(input frame_t f, input int n);
		@(posedge clk_i);
		link2.chip_select_n <= 1'b0;
		repeat (20) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			link2.sclk <= 1'b1;
			link2.sdi  <= f[15-i];
			repeat (6) @(posedge clk_i);
			r = {r[14:0], link2.sdo};
			link2.sclk <= 1'b0;
			repeat (6 + i % 2) @(posedge clk_i);
		end
		repeat (20) @(posedge clk_i);
		link2.chip_select_n <= 1'b1;
		repeat (60) @(posedge clk_i);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_values();
		xfer(16'h8000, 16'h0808);
		xfer(16'h8800, 16'h0860);
		xfer(16'h8a00, 16'h0846);
		apb(1'b0, 12'h00c, 32'h0);
		chk({15'h0, e}, 16'h0001);
	endtask
	task automatic t_write_read();
		xfer(16'h065a, 16'h0800);
		xfer(16'h8600, 16'h085a);
		xfer(16'h00ff, 16'h0808);
		xfer(16'h8000, 16'h0808);
	endtask
	task automatic t_bad_address();
		xfer(16'h9a00, 16'h0800, 16'hff00);
		xfer(16'h8400, 16'h2901);
		apb(1'b0, `APB_STAT, 32'h0);
		chk({15'h0, q[`STAT_FAULT_POS]}, 16'h0001);
		xfer(16'h0861, 16'h2960);
		xfer(16'h8400, 16'h0800);
		xfer(16'h8800, 16'h0860);
	endtask
	task automatic t_supply();
		@(posedge clk_i);
		{tsd_i, ovp_i, buck_i, aux_i} <= 7'h7f;
		@(posedge clk_i);
		{tsd_i, ovp_i, buck_i, aux_i} <= 7'h00;
		xfer(16'h8400, 16'h4f78);
		xfer(16'h0861, 16'h4f60);
		xfer(16'h8200, 16'h0800);
	endtask
	task automatic t_fault_latch();
		apb(1'b1, `APB_PINS, 32'h1d);
		gates(6'h07);
		@(posedge clk_i);
		oc_i <= 6'h20;
		warn_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		oc_i <= 6'h00;
		warn_i <= 1'b0;
		gates(6'h00);
		xfer(16'h8200, 16'h1ba0);
		apb(1'b1, `APB_PINS, 32'h1c);
		apb(1'b1, `APB_PINS, 32'he1);
		gates(6'h38);
		xfer(16'h8600, 16'h085a);
	endtask
	task automatic t_disable();
		apb(1'b1, `APB_PINS, 32'hff);
		gates(6'h00);
		apb(1'b0, `APB_STAT, 32'h0);
		chk({15'h0, q[`STAT_FAULT_POS]}, 16'h0001);
		@(posedge clk_i);
		oc_i <= 6'h01;
		repeat (5) @(posedge clk_i);
		oc_i <= 6'h00;
		apb(1'b1, `APB_PINS, 32'h1d);
		xfer(16'h8200, 16'h0800);
	endtask
	task automatic t_sleep();
		apb(1'b1, `APB_PINS, 32'h1c);
		repeat (70) @(posedge clk_i);
		@(negedge clk_i);
		chk({15'h0, asleep_o}, 16'h0001);
		apb(1'b1, `APB_PINS, 32'h1d);
		repeat (10) @(negedge clk_i);
		chk({15'h0, asleep_o}, 16'h0000);
		xfer(16'h8600, 16'h0800);
	endtask
	task automatic t_short_frame();
		chk({15'h0, link2.sdo}, 16'h0001);
		bang(16'h8400, 8);
		bang(16'h8400, 16);
		chk(r, 16'h2902);
	endtask

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic close_out();
		$display("errors=%0d comparisons=%0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		link2.sclk = 1'b0;
		link2.chip_select_n = 1'b1;
		link2.sdi = 1'b0;
		link2.sleep_n_pin = 1'b1;
		link2.driver_disable_pin = 1'b0;
		link2.high_side_phase_input = 3'h0;
		link2.low_side_phase_input = 3'h0;
		repeat (12) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		t_short_frame();
		t_reset_values();
		t_write_read();
		t_bad_address();
		t_supply();
		t_fault_latch();
		t_disable();
		t_sleep();
		close_out();
	end
	initial begin
		#900000;
		num_errors++;
		close_out();
	end
endmodule
`default_nettype wire
